// File: inc/fec_pkg.sv
// Package for the frame-sync and E-bit error counter block
// Overview of operation
// R01 - T1 multiframe mode: count each multiframe spent out of sync.
// R02 - Multiframe mode keeps counting even while receive sync is lost.
// R03 - T1 F-bit mode: count Ft errors in D4, FPS errors in ESF.
// R04 - T1 F-bit mode: counter stops while receive sync is lost.
// R05 - Framing mode bit and count-select bit choose the T1 count source.
// R06 - E1: count frame alignment word errors from time slot 0.
// R07 - E1: counter holds while receive sync loss is high.
// R08 - E1: no counting during FAS, CAS or CRC-4 multiframe search.
// R09 - Frame-sync count readable as high byte 46h, low byte 47h.
// R10 - E-bit counter works only in E1; never counts in T1.
// R11 - CRC-4 multiframing: count each received E-bit equal to zero.
// R12 - E-bit counter stops on FAS or CRC-4 sync loss, not CAS.
// R13 - E-bit count readable as high byte 48h, low byte 49h.
// R14 - Count-select 0 means F-bit errors, 1 means multiframes out of sync.
// R15 - Periodic latch and clear: one second, or 333/500 frames.
// R16 - Manual update bit rising latches and clears on next clock; the code latches and clears on the second clock after the bit rises.
// R17 - Counters saturate at maximum; count bytes read zero after reset.
// R18 - Readable counts stay stable between update events.
package fec_pkg;
    localparam int CNT_W = 16;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_FSE_HI = 8'h46;
    localparam logic [7:0] IDX_FSE_LO = 8'h47;
    localparam logic [7:0] IDX_FEBE_HI = 8'h48;
    localparam logic [7:0] IDX_FEBE_LO = 8'h49;
    localparam logic [7:0] IDX_ERR_CFG = 8'h4a;
    localparam logic [7:0] IDX_MODE = 8'h4b;
    localparam logic [7:0] IDX_INT_STAT = 8'h4c;
    localparam logic [7:0] IDX_INT_MASK = 8'h4d;
    // Error count config fields
    localparam int CFG_OOS_SEL = 1;
    localparam int CFG_ACC_MODE = 4;
    localparam int CFG_PERIOD_SEL = 5;
    localparam int CFG_MANUAL = 6;
    localparam logic [7:0] CFG_MASK = 8'h72;
    // Mode fields
    localparam int MODE_E1 = 0;
    localparam int MODE_ESF = 3;
    localparam int MODE_CRC4 = 4;
    localparam logic [7:0] MODE_MASK = 8'h19;
    // Interrupt fields
    localparam int INT_UPDATE = 0;
    localparam int INT_FSE_SAT = 1;
    localparam int INT_FEBE_SAT = 2;
    localparam int INT_W = 3;
    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int ONE_SEC_NS = 1000000000;
    localparam int ONE_SEC_CYC = ONE_SEC_NS / CLK_PERIOD_NS;
    localparam logic [9:0] T1_UPDATE_FRAMES = 10'h14d;
    localparam logic [9:0] E1_UPDATE_FRAMES = 10'h1f4;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [15:0] CNT_MAX = 16'hffff;

    typedef struct packed {
        logic mf_boundary;
        logic frame;
        logic ft_err;
        logic fps_err;
        logic fas_word_err;
        logic ebit_zero;
    } fec_evt_s;

    typedef struct packed {
        logic rx_sync_loss;
        logic fas_search;
        logic cas_mf_search;
        logic crc4_mf_search;
    } fec_sync_s;
endpackage

// File: core/fec_counters.sv
// Frame-sync and E-bit error counters with AHB-Lite register slave
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/100ps
module fec_counters #(
    parameter int ONE_SEC_CYCLES = fec_pkg::ONE_SEC_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire fec_pkg::fec_evt_s rx_evt,
    input wire fec_pkg::fec_sync_s rx_sync,
    output logic irq
);
    localparam int SEC_W = $clog2(ONE_SEC_CYCLES + 1);

    // Bus state
    logic wr_pend_q, wr_pend_d;
    logic [7:0] wr_idx_q, wr_idx_d;
    logic [31:0] rdata_q, rdata_d;
    // Control registers
    logic [7:0] cfg_q, cfg_d;
    logic [7:0] mode_q, mode_d;
    logic [fec_pkg::INT_W-1:0] int_stat_q, int_stat_d;
    logic [fec_pkg::INT_W-1:0] int_mask_q, int_mask_d;
    logic irq_q, irq_d;
    // Counting state
    logic [fec_pkg::CNT_W-1:0] fse_cnt_q, fse_cnt_d;
    logic [fec_pkg::CNT_W-1:0] febe_cnt_q, febe_cnt_d;
    logic [fec_pkg::CNT_W-1:0] fse_shadow_q, fse_shadow_d;
    logic [fec_pkg::CNT_W-1:0] febe_shadow_q, febe_shadow_d;
    logic [SEC_W-1:0] sec_cnt_q, sec_cnt_d;
    logic [9:0] frm_cnt_q, frm_cnt_d;
    logic manual_prev_q, manual_prev_d;
    logic manual_tick_q, manual_tick_d;

    logic addr_ok;
    logic [7:0] addr_idx;
    logic wr_now;
    logic [7:0] wdat;
    logic update;
    logic fse_inc, febe_inc;
    logic e1, esf, oos_sel, crc4;
    logic [9:0] frame_limit;

    assign e1 = mode_q[fec_pkg::MODE_E1];
    assign esf = mode_q[fec_pkg::MODE_ESF];
    assign crc4 = mode_q[fec_pkg::MODE_CRC4];
    assign oos_sel = cfg_q[fec_pkg::CFG_OOS_SEL];
    assign frame_limit = e1 ? fec_pkg::E1_UPDATE_FRAMES
                            : fec_pkg::T1_UPDATE_FRAMES;

    // Address phase decode; index is haddr[9:2], so haddr[1:0] is ignored
    assign addr_idx = haddr[9:2];
    assign addr_ok = hsel && hready && (htrans == fec_pkg::HTRANS_NONSEQ);
    assign wr_now = wr_pend_q;
    assign wdat = hwdata[7:0];

    // Event qualification
    always_comb begin
        fse_inc = 1'b0;
        febe_inc = 1'b0;
        if (e1) begin
            fse_inc = rx_evt.fas_word_err && !rx_sync.rx_sync_loss //R06 R07
                && !rx_sync.fas_search && !rx_sync.cas_mf_search //R08
                && !rx_sync.crc4_mf_search; //R08
            febe_inc = crc4 && rx_evt.ebit_zero //R11
                && !rx_sync.fas_search //R12
                && !rx_sync.crc4_mf_search; //R12 R10
        end else if (oos_sel) begin
            // Sync loss enables counting in this mode instead of stopping it
            fse_inc = rx_evt.mf_boundary && rx_sync.rx_sync_loss; //R01 R02 R14
        end else begin
            fse_inc = !rx_sync.rx_sync_loss //R04 R14
                && (esf ? rx_evt.fps_err : rx_evt.ft_err); //R03 R05
        end
    end

    // Update period generation
    always_comb begin
        sec_cnt_d = sec_cnt_q;
        frm_cnt_d = frm_cnt_q;
        manual_prev_d = cfg_q[fec_pkg::CFG_MANUAL];
        manual_tick_d = cfg_q[fec_pkg::CFG_MANUAL] && !manual_prev_q
            && cfg_q[fec_pkg::CFG_ACC_MODE]; //R16
        update = 1'b0;
        if (cfg_q[fec_pkg::CFG_ACC_MODE]) begin
            update = manual_tick_q; //R16
            sec_cnt_d = '0;
            frm_cnt_d = '0;
        end else if (cfg_q[fec_pkg::CFG_PERIOD_SEL]) begin
            sec_cnt_d = '0;
            if (rx_evt.frame) begin
                if (frm_cnt_q >= frame_limit - 10'h001) begin
                    frm_cnt_d = '0;
                    update = 1'b1; //R15
                end else begin
                    frm_cnt_d = frm_cnt_q + 10'h001;
                end
            end
        end else begin
            frm_cnt_d = '0;
            if (sec_cnt_q >= SEC_W'(ONE_SEC_CYCLES - 1)) begin
                sec_cnt_d = '0;
                update = 1'b1; //R15
            end else begin
                sec_cnt_d = sec_cnt_q + SEC_W'(1);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sec_cnt_q <= '0;
            frm_cnt_q <= '0;
            manual_prev_q <= 1'b0;
            manual_tick_q <= 1'b0;
        end else begin
            sec_cnt_q <= sec_cnt_d;
            frm_cnt_q <= frm_cnt_d;
            manual_prev_q <= manual_prev_d;
            manual_tick_q <= manual_tick_d;
        end
    end

    // Counters; an event on the update cycle starts the new interval
    always_comb begin
        fse_cnt_d = fse_cnt_q;
        febe_cnt_d = febe_cnt_q;
        fse_shadow_d = fse_shadow_q;
        febe_shadow_d = febe_shadow_q;
        if (update) begin
            fse_shadow_d = fse_cnt_q; //R15 R18
            febe_shadow_d = febe_cnt_q; //R15 R18
            fse_cnt_d = {{(fec_pkg::CNT_W-1){1'b0}}, fse_inc};
            febe_cnt_d = {{(fec_pkg::CNT_W-1){1'b0}}, febe_inc};
        end else begin
            if (fse_inc && fse_cnt_q != fec_pkg::CNT_MAX) begin
                fse_cnt_d = fse_cnt_q + 16'h0001; //R17
            end
            if (febe_inc && febe_cnt_q != fec_pkg::CNT_MAX) begin
                febe_cnt_d = febe_cnt_q + 16'h0001; //R17
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fse_cnt_q <= '0;
            febe_cnt_q <= '0;
            fse_shadow_q <= '0; //R17
            febe_shadow_q <= '0; //R17
        end else begin
            fse_cnt_q <= fse_cnt_d;
            febe_cnt_q <= febe_cnt_d;
            fse_shadow_q <= fse_shadow_d;
            febe_shadow_q <= febe_shadow_d;
        end
    end

    // Write strobes in the data phase; count bytes take no write
    logic wr_cfg, wr_mode, wr_mask, wr_clr;
    assign wr_cfg = wr_now && (wr_idx_q == fec_pkg::IDX_ERR_CFG);
    assign wr_mode = wr_now && (wr_idx_q == fec_pkg::IDX_MODE);
    assign wr_mask = wr_now && (wr_idx_q == fec_pkg::IDX_INT_MASK);
    assign wr_clr = wr_now && (wr_idx_q == fec_pkg::IDX_INT_STAT);

    // Bus write pipeline and control registers
    always_comb begin
        wr_pend_d = addr_ok && hwrite;
        wr_idx_d = addr_ok ? addr_idx : wr_idx_q;
        cfg_d = cfg_q;
        mode_d = mode_q;
        if (wr_cfg) begin
            cfg_d = wdat & fec_pkg::CFG_MASK;
        end
        if (wr_mode) begin
            mode_d = wdat & fec_pkg::MODE_MASK;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_idx_q <= 8'h00;
            cfg_q <= 8'h00;
            mode_q <= 8'h00;
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_idx_q <= wr_idx_d;
            cfg_q <= cfg_d;
            mode_q <= mode_d;
        end
    end

    // Saturation flag only when the step really reaches the top
    // An update in the same cycle restarts the count instead
    logic fse_last_step, febe_last_step;
    assign fse_last_step = !update && fse_inc
        && (fse_cnt_q == fec_pkg::CNT_MAX - 16'h0001);
    assign febe_last_step = !update && febe_inc
        && (febe_cnt_q == fec_pkg::CNT_MAX - 16'h0001);

    // Interrupt status, mask and level output
    always_comb begin
        int_mask_d = int_mask_q;
        int_stat_d = int_stat_q;
        if (wr_mask) begin
            int_mask_d = wdat[fec_pkg::INT_W-1:0];
        end
        if (wr_clr) begin
            int_stat_d = int_stat_q & ~wdat[fec_pkg::INT_W-1:0];
        end
        // Hardware set wins over a clear in the same cycle
        if (update) begin
            int_stat_d[fec_pkg::INT_UPDATE] = 1'b1;
        end
        if (fse_last_step) begin
            int_stat_d[fec_pkg::INT_FSE_SAT] = 1'b1;
        end
        if (febe_last_step) begin
            int_stat_d[fec_pkg::INT_FEBE_SAT] = 1'b1;
        end
        // One cycle late, but glitch free at the pin
        irq_d = |(int_stat_q & int_mask_q);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_stat_q <= '0;
            int_mask_q <= '0;
            irq_q <= 1'b0;
        end else begin
            int_stat_q <= int_stat_d;
            int_mask_q <= int_mask_d;
            irq_q <= irq_d;
        end
    end

    // Read mux; loaded at the address edge, held until the next read
    always_comb begin
        rdata_d = rdata_q;
        if (addr_ok && !hwrite) begin
            case (addr_idx)
                fec_pkg::IDX_FSE_HI: rdata_d = {24'h0, fse_shadow_q[15:8]}; //R09
                fec_pkg::IDX_FSE_LO: rdata_d = {24'h0, fse_shadow_q[7:0]}; //R09
                fec_pkg::IDX_FEBE_HI: rdata_d = {24'h0, febe_shadow_q[15:8]}; //R13
                fec_pkg::IDX_FEBE_LO: rdata_d = {24'h0, febe_shadow_q[7:0]}; //R13
                fec_pkg::IDX_ERR_CFG: rdata_d = {24'h0, cfg_q};
                fec_pkg::IDX_MODE: rdata_d = {24'h0, mode_q};
                fec_pkg::IDX_INT_STAT: rdata_d = {29'h0, int_stat_q};
                fec_pkg::IDX_INT_MASK: rdata_d = {29'h0, int_mask_q};
                default: rdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 32'h0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Zero wait states and OKAY only; flops so every output is registered
    logic ready_q, resp_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ready_q <= 1'b1;
            resp_q <= 1'b0;
        end else begin
            ready_q <= 1'b1;
            resp_q <= 1'b0;
        end
    end

    assign hrdata = rdata_q;
    assign hreadyout = ready_q;
    assign hresp = resp_q;
    assign irq = irq_q;
endmodule

// File: sim/fec_counters_props.sv
// Bus and interrupt checker for the error counter block
`timescale 1ns/100ps
module fec_counters_props (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic irq
);
    logic first_q, rd_q, mwr_q, mseen_q, tk;
    assign tk = hsel && hready && htrans == fec_pkg::HTRANS_NONSEQ;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            first_q <= 1'b1;
            rd_q <= 1'b0;
            mwr_q <= 1'b0;
            mseen_q <= 1'b0;
        end else begin
            first_q <= 1'b0;
            rd_q <= tk && !hwrite;
            mwr_q <= tk && hwrite && haddr[9:2] == fec_pkg::IDX_INT_MASK;
            mseen_q <= mseen_q || mwr_q;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_rd_far;
        tk && !hwrite ##0 haddr[9:2] > fec_pkg::IDX_INT_MASK;
    endsequence
    sequence s_mask_off;
        mwr_q && hwdata[2:0] == 3'h0;
    endsequence
    a_ready_high: assert property (hreadyout)
        else $error("ready low");
    a_resp_okay: assert property (!hresp)
        else $error("error response");
    a_byte_wide: assert property (rd_q |-> hrdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_unmapped_zero: assert property (s_rd_far |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_read_hold: assert property (!(tk && !hwrite) |=> $stable(hrdata))
        else $error("read data moved");
    a_reset_quiet: assert property (first_q |-> !irq && hrdata == 0)
        else $error("outputs not clear after reset");
    a_irq_unmasked: assert property (!mseen_q |-> !irq)
        else $error("irq without mask");
    a_mask_irq_off: assert property (s_mask_off |-> ##2 !irq)
        else $error("irq despite zero mask");
endmodule
bind fec_counters fec_counters_props u_props (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout,
    .hresp, .irq);

// File: sim/fec_rx_model.sv
// Receive synchronizer stand-in: event pulses and sync levels
`timescale 1ns/100ps
module fec_rx_model (
    input wire logic hclk,
    input wire logic go,
    input wire fec_pkg::fec_evt_s evt_in,
    input wire fec_pkg::fec_sync_s sync_in,
    output fec_pkg::fec_evt_s rx_evt,
    output fec_pkg::fec_sync_s rx_sync
);
    // Events are delayed one cycle; an input held high repeats every cycle
    always_ff @(posedge hclk) begin
        rx_evt <= go ? evt_in : '0;
        rx_sync <= sync_in;
    end
endmodule

// File: sim/fec_counters_tb_top.sv
// Random and corner tests of the error counter block
`timescale 1ns/100ps
module fec_counters_tb_top;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, go = 0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0] htrans = '0;
    logic hreadyout, hresp, irq;
    logic [15:0] fse, febe, pf = '0, pe = '0;
    logic [7:0] md, cfg;
    logic [1:0] x;
    fec_pkg::fec_evt_s evt_in = '0, rx_evt;
    fec_pkg::fec_sync_s sync_in = '0, rx_sync;
    int errors = 0, cmp_count = 0, n;
    always #10 hclk = ~hclk;
    localparam int SEC_CYC = 5000;
    fec_counters #(.ONE_SEC_CYCLES(SEC_CYC)) dut (.hclk, .hresetn, .hsel,
        .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rx_evt,
        .rx_sync, .irq);
    fec_rx_model u_rx (.hclk, .go, .evt_in, .sync_in, .rx_evt, .rx_sync);
    function automatic logic [1:0] inc(fec_pkg::fec_evt_s e,
        fec_pkg::fec_sync_s s, logic [7:0] m, logic [7:0] c);
        logic f, b;
        if (!m[0]) f = c[1] ? e.mf_boundary && s.rx_sync_loss
            : !s.rx_sync_loss && (m[3] ? e.fps_err : e.ft_err);
        else f = e.fas_word_err && !(|s);
        b = m[0] && m[4] && e.ebit_zero
            && !s.fas_search && !s.crc4_mf_search;
        return {f, b};
    endfunction
    task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d);
        hsel <= 1'b1;
        haddr <= {22'h0, i, 2'h0};
        htrans <= fec_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic chk_reg(input logic [7:0] i, input logic [7:0] e);
        bus(1'b0, i, 8'h00);
        cmp_count++;
        if (rd !== {24'h0, e}) begin
            errors++;
            $display("[ERR] %0t reg %h got %h exp %h", $time, i, rd, e);
        end
    endtask
    task automatic chk_irq(input logic e);
        cmp_count++;
        if (irq !== e) begin
            errors++;
            $display("[ERR] %0t irq got %b", $time, irq);
        end
    endtask
    task automatic counts(input logic [15:0] f, input logic [15:0] e);
        chk_reg(fec_pkg::IDX_FSE_HI, f[15:8]);
        chk_reg(fec_pkg::IDX_FSE_LO, f[7:0]);
        chk_reg(fec_pkg::IDX_FEBE_HI, e[15:8]);
        chk_reg(fec_pkg::IDX_FEBE_LO, e[7:0]);
    endtask
    task automatic final_report;
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #1900000;
        errors++;
        final_report();
    end
    initial begin
        void'($urandom(93));
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        // Case 16 drives a pulse every cycle to reach saturation
        for (int i = 0; i < 17; i++) begin
            md = {3'h0, i[2], i[1], 2'h0, i[0] && i < 16};
            cfg = {6'h04, i[3] || i == 16, 1'b0};
            bus(1'b1, fec_pkg::IDX_MODE, md);
            bus(1'b1, fec_pkg::IDX_ERR_CFG, cfg);
            sync_in <= (i == 16) ? 4'h8 : 4'($urandom);
            fse = '0;
            febe = '0;
            n = (i == 16) ? 65540 : $urandom_range(40, 1);
            repeat (n) begin
                evt_in <= (i == 16) ? 6'h20 : 6'($urandom) & 6'h2f;
                go <= 1'b1;
                @(posedge hclk);
                x = inc(evt_in, sync_in, md, cfg);
                if (fse != fec_pkg::CNT_MAX) fse += 16'(x[1]);
                febe += 16'(x[0]);
            end
            go <= 1'b0;
            counts(pf, pe);
            bus(1'b1, fec_pkg::IDX_ERR_CFG, cfg | 8'h40);
            repeat (2) @(posedge hclk);
            counts(fse, febe);
            pf = fse;
            pe = febe;
            $display("test %0d done", i);
        end
        // Frame period: each T1 frame of the interval carries an Ft error
        bus(1'b1, fec_pkg::IDX_MODE, 8'h00);
        bus(1'b1, fec_pkg::IDX_ERR_CFG, 8'h20);
        sync_in <= '0;
        evt_in <= 6'h18;
        go <= 1'b1;
        repeat (int'(fec_pkg::T1_UPDATE_FRAMES)) @(posedge hclk);
        go <= 1'b0;
        repeat (2) @(posedge hclk);
        // Error on the update frame opens the next interval
        pf = 16'(fec_pkg::T1_UPDATE_FRAMES) - 16'h0001;
        pe = '0;
        counts(pf, pe);
        // One-second period latches that leftover error
        bus(1'b1, fec_pkg::IDX_ERR_CFG, 8'h00);
        repeat (SEC_CYC) @(posedge hclk);
        bus(1'b1, fec_pkg::IDX_ERR_CFG, 8'h10);
        pf = 16'h0001;
        counts(pf, pe);
        $display("test period done");
        chk_reg(fec_pkg::IDX_INT_STAT, 8'h03);
        chk_irq(1'b0);
        bus(1'b1, fec_pkg::IDX_INT_MASK, 8'h01);
        repeat (2) @(posedge hclk);
        chk_irq(1'b1);
        bus(1'b1, fec_pkg::IDX_INT_STAT, 8'h01);
        repeat (2) @(posedge hclk);
        chk_irq(1'b0);
        bus(1'b1, fec_pkg::IDX_INT_MASK, 8'h00);
        bus(1'b1, fec_pkg::IDX_FSE_LO, 8'h5a);
        counts(pf, pe);
        chk_reg(8'h7f, 8'h00);
        $display("test irq done");
        final_report();
    end
endmodule
